//--- rtl/lap_pkg.sv
package lap_pkg;
  localparam int BANK_W = 3;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int DATA_W = 32;
  localparam int BEATS_PER_BURST = 8;
  localparam int BEATS_PER_CYCLE = 2;
  localparam int DATA_CYCLES = BEATS_PER_BURST / BEATS_PER_CYCLE;
  localparam int FIFO_DEPTH = 32;
  localparam int TRACKERS = 4;
  localparam logic [1:0] SLOT_CMD = 2'h0;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_PRE,
    CMD_RD,
    CMD_WR
  } sdram_cmd_t;

  typedef struct packed {
    logic wr;
    logic ap;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic [DATA_CYCLES*BEATS_PER_CYCLE*DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    sdram_cmd_t cmd;
    logic ap;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } mem_cmd_t;
endpackage

//--- rtl/lap_sched.sv
`timescale 1ns/100ps
// How it works
// [R1] No look-ahead: precharge, activate, then access
// [R2] Look-ahead inspects queue to pick auto-precharge
// [R3] After auto-precharge only activate is needed
// [R4] Queued write to other row sets auto-precharge
// [R5] Eight beats, two per cycle, four cycles
// [R6] Request taken when ready output is high
// [R7] Closed bank: activate then read
// [R8] User should request precharge before row change
// [R9] User should not close a reopened row
// [R10] Per-request flag closes or keeps page
// [R11] Full tracker pool evicts one open page
// [R12] Address captured together with accepted request
// [R13] One command per two cycles, NOP between
// [R14] Reset leaves banks closed, trackers free
module req_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [WIDTH-1:0] rdata_out,
  output logic rvalid_out,
  input wire logic rready_in,
  output logic [WIDTH-1:0] peek_out,
  output logic peek_valid_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_st_t;
  fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  assign wready_out = (s_q.cnt != (AW+1)'(DEPTH));
  assign rvalid_out = (s_q.cnt != '0);
  assign push = wvalid_in && wready_out && ce_in;
  assign pop = rvalid_out && rready_in && ce_in;
  assign rdata_out = mem[s_q.rp];
  // Entry behind the head, used by look-ahead
  assign peek_out = mem[s_q.rp + AW'(1)];
  assign peek_valid_out = (s_q.cnt > (AW+1)'(1));
  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + AW'(1);
    if (pop) s_d.rp = s_q.rp + AW'(1);
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) s_q <= '0;
    else s_q <= s_d;
  end
  always_ff @(posedge clk_in) begin
    if (push) mem[s_q.wp] <= wdata_in;
  end
endmodule

module lap_sched
  import lap_pkg::*;
#(
  parameter int TRK = lap_pkg::TRACKERS,
  parameter int DEPTH = lap_pkg::FIFO_DEPTH
) (
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CE_IN,
  input wire logic LOOKAHEAD_EN_IN,
  input wire logic REQ_VALID_IN,
  input wire lap_pkg::req_t REQ_IN,
  output logic REQ_READY_OUT,
  output lap_pkg::mem_cmd_t MEM_CMD_OUT,
  output logic [BEATS_PER_CYCLE*DATA_W-1:0] MEM_WDATA_OUT,
  output logic MEM_WDATA_VALID_OUT
);
  import lap_pkg::*;
  localparam int TW = (TRK > 1) ? $clog2(TRK) : 1;
  localparam int RW = $bits(req_t);
  localparam int DW = BEATS_PER_CYCLE * DATA_W;
  localparam int OW = $clog2(DEPTH) + 1;
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_ACT, ST_ACC} st_t;
  typedef struct packed {
    st_t st;
    logic slot;
    logic [TRK-1:0] tv;
    logic [TRK-1:0][BANK_W-1:0] tb;
    logic [TRK-1:0][ROW_W-1:0] tr;
    logic [TW-1:0] vic;
    logic [TW-1:0] hit;
    logic [2:0] beat;
    logic [DATA_CYCLES-1:0][DW-1:0] wbuf;
    logic ready;
    logic [OW-1:0] occ;
    mem_cmd_t cmd;
    logic [DW-1:0] wd;
    logic wdv;
  } st_all_t;
  st_all_t s_q, s_d;
  req_t head, nxt;
  logic head_v, nxt_v, pop, fifo_ready;
  logic miss, hit_any, free_any, ap_now;
  logic [TW-1:0] hit_idx, free_idx;
  logic take;

  // Request captured with its address when ready is high
  req_fifo #(.WIDTH(RW), .DEPTH(DEPTH)) u_fifo (
    .clk_in(REF_CLK_IN), .rst_n_in(RESET_N_IN), .ce_in(CE_IN),
    .wdata_in(REQ_IN), .wvalid_in(take), .wready_out(fifo_ready), // [R6] [R12]
    .rdata_out(head), .rvalid_out(head_v), .rready_in(pop),
    .peek_out(nxt), .peek_valid_out(nxt_v)
  );

  // Lowest free entry is taken; one bank never sits in two entries
  always_comb begin
    hit_any = 1'b0;
    free_any = 1'b0;
    hit_idx = '0;
    free_idx = '0;
    miss = 1'b0;
    for (int i = TRK-1; i >= 0; i--) begin
      if (s_q.tv[i] && s_q.tb[i] == head.bank) begin
        hit_any = 1'b1;
        hit_idx = TW'(i);
        miss = (s_q.tr[i] != head.row);
      end
      if (!s_q.tv[i]) begin
        free_any = 1'b1;
        free_idx = TW'(i);
      end
    end
  end

  // Close page if user asks, or queued access hits same bank other row
  // Only the entry behind the head is seen, which keeps the compare small
  always_comb begin
    ap_now = head.ap; // [R10]
    if (LOOKAHEAD_EN_IN && nxt_v && nxt.bank == head.bank && nxt.row != head.row) ap_now = 1'b1; // [R2] [R4]
  end

  // Head leaves the queue with its access command
  assign pop = (s_q.st == ST_ACC) && (s_q.slot == 1'b0) && (s_q.beat == '0);
  // Take only on the registered ready the user sees, so nothing is lost at full
  assign take = REQ_VALID_IN && s_q.ready; // [R6]

  always_comb begin
    s_d = s_q;
    // Own count lets ready be registered yet exact at the full mark
    s_d.occ = s_q.occ + OW'(take) - OW'(pop);
    s_d.ready = (s_d.occ != OW'(DEPTH)); // [R6]
    s_d.cmd = '0;
    s_d.cmd.cmd = CMD_NOP;
    s_d.wdv = 1'b0;
    s_d.wd = '0;
    // Command slots alternate; odd slot is always NOP
    s_d.slot = ~s_q.slot; // [R13]
    if (s_q.beat != '0) begin
      s_d.wdv = 1'b1; // [R5]
      s_d.wd = s_q.wbuf[3'(DATA_CYCLES) - s_q.beat];
      s_d.beat = s_q.beat - 3'h1;
    end
    if (s_q.slot == 1'b0) begin
      case (s_q.st)
        ST_IDLE: begin
          if (head_v) begin
            if (hit_any && !miss) s_d.st = ST_ACC;
            else if (hit_any) s_d.st = ST_PRE; // [R1]
            else if (free_any) s_d.st = ST_ACT; // [R3] [R7]
            // Pool full: close the page in the round-robin victim entry first, as an untracked open
            // bank would later take an activate while still open
            else s_d.st = ST_PRE; // [R11]
            s_d.hit = hit_any ? hit_idx : (free_any ? free_idx : s_q.vic);
            if (!hit_any && !free_any) s_d.vic = s_q.vic + TW'(1); // [R11]
            s_d.slot = 1'b0;
          end
        end
        ST_PRE: begin
          s_d.cmd.cmd = CMD_PRE; // [R1]
          // Tracker's bank: on eviction it differs from the head's bank
          s_d.cmd.bank = s_q.tb[s_q.hit]; // [R11]
          s_d.tv[s_q.hit] = 1'b0;
          s_d.st = ST_ACT;
        end
        ST_ACT: begin
          s_d.cmd.cmd = CMD_ACT; // [R3] [R7]
          s_d.cmd.bank = head.bank;
          s_d.cmd.row = head.row;
          s_d.tv[s_q.hit] = 1'b1;
          s_d.tb[s_q.hit] = head.bank;
          s_d.tr[s_q.hit] = head.row;
          s_d.st = ST_ACC;
        end
        ST_ACC: begin
          // Reads also wait for write data to drain, keeping the data bus in order
          if (s_q.beat == '0) begin
            s_d.cmd.cmd = head.wr ? CMD_WR : CMD_RD;
            s_d.cmd.ap = ap_now;
            s_d.cmd.bank = head.bank;
            s_d.cmd.row = head.row;
            s_d.cmd.col = head.col;
            if (ap_now) s_d.tv[s_q.hit] = 1'b0; // [R3]
            if (head.wr) begin
              s_d.wbuf = head.wdata;
              s_d.beat = 3'(DATA_CYCLES); // [R5]
            end
            s_d.st = ST_IDLE;
          end
        end
        default: s_d.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s_q <= '0; // [R14]
      s_q.cmd.cmd <= CMD_NOP;
    end else if (CE_IN) begin
      s_q <= s_d;
    end
  end

  assign REQ_READY_OUT = s_q.ready;
  assign MEM_CMD_OUT = s_q.cmd;
  assign MEM_WDATA_OUT = s_q.wd;
  assign MEM_WDATA_VALID_OUT = s_q.wdv;

  // Checks watch registered state, so they see what the command bus shows
  property p_nop_slot;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && s_q.cmd.cmd != CMD_NOP |=> s_q.cmd.cmd == CMD_NOP;
  endproperty
  a_nop_slot: assert property (p_nop_slot) else $error("Two commands back to back"); // [R13]

  property p_burst;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && s_q.cmd.cmd == CMD_WR |=> MEM_WDATA_VALID_OUT[*4];
  endproperty
  a_burst: assert property (p_burst) else $error("Write burst too short"); // [R5]

  property p_pre_act;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && s_q.cmd.cmd == CMD_PRE ##1 CE_IN ##1 CE_IN |-> s_q.cmd.cmd == CMD_ACT;
  endproperty
  a_pre_act: assert property (p_pre_act) else $error("Precharge not followed by activate"); // [R1]

  property p_ap;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && pop && LOOKAHEAD_EN_IN && nxt_v && nxt.bank == head.bank && nxt.row != head.row |=> s_q.cmd.ap;
  endproperty
  a_ap: assert property (p_ap) else $error("Missing auto-precharge"); // [R4]

  property p_burst_end;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (CE_IN && s_q.cmd.cmd == CMD_WR) ##1 CE_IN[*4] |=> !MEM_WDATA_VALID_OUT;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("Write data runs past four cycles"); // [R5]

  property p_pre_open;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && s_q.st == ST_PRE && s_q.slot == 1'b0 |-> s_q.tv[s_q.hit];
  endproperty
  a_pre_open: assert property (p_pre_open) else $error("Precharge of an untracked page"); // [R11]

  property p_act_free;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && s_q.st == ST_ACT && s_q.slot == 1'b0 |-> !s_q.tv[s_q.hit];
  endproperty
  a_act_free: assert property (p_act_free) else $error("Activate into a tracked open page"); // [R3]

  property p_act_acc;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (CE_IN && s_q.cmd.cmd == CMD_ACT) ##1 CE_IN |=> (s_q.cmd.cmd == CMD_RD || s_q.cmd.cmd == CMD_WR)
        && s_q.cmd.bank == $past(s_q.cmd.bank, 2);
  endproperty
  a_act_acc: assert property (p_act_acc) else $error("Activate not followed by its access"); // [R7]

  property p_ready_room;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      REQ_READY_OUT |-> fifo_ready;
  endproperty
  a_ready_room: assert property (p_ready_room) else $error("Ready shown while queue is full"); // [R6]

  property p_user_ap;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && pop && head.ap |=> s_q.cmd.ap;
  endproperty
  a_user_ap: assert property (p_user_ap) else $error("User close request ignored"); // [R10]

  property p_la_off;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && pop && !LOOKAHEAD_EN_IN && !head.ap |=> !s_q.cmd.ap;
  endproperty
  a_la_off: assert property (p_la_off) else $error("Auto-precharge without look-ahead"); // [R1]

  property p_trk_free;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && pop && ap_now |=> !s_q.tv[$past(s_q.hit)];
  endproperty
  a_trk_free: assert property (p_trk_free) else $error("Closed page still tracked"); // [R3]

  property p_pop_head;
    @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      CE_IN && pop |-> head_v;
  endproperty
  a_pop_head: assert property (p_pop_head) else $error("Access without a captured request"); // [R12]
endmodule

//--- verif/user_model.sv
`timescale 1ns/100ps
module user_model
  import lap_pkg::*;
(
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out,
  output lap_pkg::req_t req_out
);
  initial begin
    valid_out = 1'b0;
    req_out = '0;
  end
  // Request and address held together until taken
  task automatic send(input req_t r);
    @(posedge clk_in);
    valid_out <= 1'b1;
    req_out <= r;
    do @(posedge clk_in); while (ready_in !== 1'b1);
    valid_out <= 1'b0;
    req_out <= ~r;
  endtask
endmodule

//--- verif/lap_sched_tb_top.sv
`timescale 1ns/100ps
module lap_sched_tb_top;
  import lap_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic la_en = 1'b0;
  logic rdy;
  logic vld;
  logic wv;
  req_t rq;
  mem_cmd_t mc;
  mem_cmd_t prev = '0;
  logic [63:0] wd;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int k = 0;
  mem_cmd_t seen[$];
  always #5 clk = ~clk;
  lap_sched lap_sched_inst (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(1'b1), .LOOKAHEAD_EN_IN(la_en),
    .REQ_VALID_IN(vld), .REQ_IN(rq), .REQ_READY_OUT(rdy), .MEM_CMD_OUT(mc), .MEM_WDATA_OUT(wd),
    .MEM_WDATA_VALID_OUT(wv));
  user_model user_model_inst (.clk_in(clk), .ready_in(rdy), .valid_out(vld), .req_out(rq));
  task automatic print_verdict(input bit timeout);
    if (timeout) err_total++;
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) print_verdict(1'b1);
  end
  // Commands collected in issue order; data beats checked as they leave
  always @(posedge clk) begin
    if (rst_n === 1'b1) begin
      if (mc.cmd !== CMD_NOP) begin
        seen.push_back(mc);
        chk(prev.cmd, CMD_NOP);
      end
      if (prev.cmd === CMD_WR) chk(wv, 1'b1);
      if (wv === 1'b1) begin
        chk(wd, {32'ha1 + 32'(2 * k), 32'ha0 + 32'(2 * k)});
        k = (k + 1) % 4;
      end
    end
    prev = mc;
  end
  function automatic req_t mk(input logic w, input logic a, input int b, input int r);
    req_t q;
    q = '0;
    q.wr = w;
    q.ap = a;
    q.bank = 3'(b);
    q.row = 14'(r);
    for (int i = 0; i < 8; i++) q.wdata[i*32 +: 32] = 32'ha0 + 32'(i);
    return q;
  endfunction
  // Row of a precharge is not meaningful, so it is left out
  task automatic exp_cmd(input sdram_cmd_t c, input logic a, input int b, input int r);
    mem_cmd_t g;
    for (int i = 0; i < 200 && seen.size() == 0; i++) @(posedge clk);
    g = (seen.size() > 0) ? seen.pop_front() : '0;
    chk({g.cmd, g.bank}, {c, 3'(b)});
    if (c == CMD_RD || c == CMD_WR) chk(g.ap, a);
    if (c != CMD_PRE) chk(g.row, 14'(r));
  endtask
  task automatic t_no_lookahead();
    user_model_inst.send(mk(1, 0, 0, 0));
    user_model_inst.send(mk(1, 0, 0, 1));
    exp_cmd(CMD_ACT, 0, 0, 0);
    exp_cmd(CMD_WR, 0, 0, 0);
    exp_cmd(CMD_PRE, 0, 0, 0);
    exp_cmd(CMD_ACT, 0, 0, 1);
    exp_cmd(CMD_WR, 0, 0, 1);
  endtask
  task automatic t_lookahead_write();
    @(posedge clk);
    la_en <= 1'b1;
    user_model_inst.send(mk(1, 0, 1, 0));
    user_model_inst.send(mk(1, 0, 1, 1));
    exp_cmd(CMD_ACT, 0, 1, 0);
    exp_cmd(CMD_WR, 1, 1, 0);
    exp_cmd(CMD_ACT, 0, 1, 1);
    exp_cmd(CMD_WR, 0, 1, 1);
  endtask
  task automatic t_user_ap_read();
    // Look-ahead off, so only the user's flag can close the page
    @(posedge clk);
    la_en <= 1'b0;
    user_model_inst.send(mk(0, 1, 2, 0));
    user_model_inst.send(mk(0, 0, 2, 5));
    exp_cmd(CMD_ACT, 0, 2, 0);
    exp_cmd(CMD_RD, 1, 2, 0);
    exp_cmd(CMD_ACT, 0, 2, 5);
    exp_cmd(CMD_RD, 0, 2, 5);
  endtask
  // Same-row hit, then a fifth bank pushes the oldest page out
  task automatic t_evict();
    user_model_inst.send(mk(0, 0, 3, 0));
    user_model_inst.send(mk(0, 0, 3, 0));
    user_model_inst.send(mk(0, 0, 4, 0));
    exp_cmd(CMD_ACT, 0, 3, 0);
    exp_cmd(CMD_RD, 0, 3, 0);
    exp_cmd(CMD_RD, 0, 3, 0);
    exp_cmd(CMD_PRE, 0, 0, 0);
    exp_cmd(CMD_ACT, 0, 4, 0);
    exp_cmd(CMD_RD, 0, 4, 0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_no_lookahead();
    t_lookahead_write();
    t_user_ap_read();
    t_evict();
    repeat (10) @(posedge clk);
    chk(seen.size(), 0);
    chk(k, 0);
    print_verdict(1'b0);
  end
endmodule
